// file: rtl/pccp_pkg.sv
package pccp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int STB_NS = 500;
  localparam int ACK_NS = 5000;
  localparam int INIT_NS = 50000;
  localparam int BUZZ_MS = 1000;
  // Glitch filter at half the minimum strobe width
  localparam int STB_FILT_CYC = (STB_NS / CLK_NS) / 2;
  localparam int ACK_CYC = ACK_NS / CLK_NS;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUZZ_CYC = (BUZZ_MS * 1000000) / CLK_NS;
  localparam logic [15:0] STB_LAST = 16'(STB_FILT_CYC - 1);
  localparam logic [15:0] ACK_LAST = 16'(ACK_CYC - 1);
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [7:0] C_NUL = 8'h00;
  localparam logic [7:0] C_BEL = 8'h07;
  localparam logic [7:0] C_HT = 8'h09;
  localparam logic [7:0] C_LF = 8'h0a;
  localparam logic [7:0] C_VT = 8'h0b;
  localparam logic [7:0] C_FF = 8'h0c;
  localparam logic [7:0] C_CR = 8'h0d;
  localparam logic [7:0] C_SO = 8'h0e;
  localparam logic [7:0] C_SI = 8'h0f;
  localparam logic [7:0] C_DC1 = 8'h11;
  localparam logic [7:0] C_DC2 = 8'h12;
  localparam logic [7:0] C_DC3 = 8'h13;
  localparam logic [7:0] C_DC4 = 8'h14;
  localparam logic [7:0] C_CAN = 8'h18;
  localparam logic [7:0] C_ESC = 8'h1b;
  localparam logic [7:0] C_SPACE = 8'h20;
  localparam logic [7:0] C_DEL = 8'h7f;
  localparam logic [7:0] E_ULINE = 8'h2d;
  localparam logic [7:0] E_SP8 = 8'h30;
  localparam logic [7:0] E_SP7 = 8'h31;
  localparam logic [7:0] E_SPVAR = 8'h32;
  localparam logic [7:0] E_SPN = 8'h33;
  localparam logic [7:0] E_SET2 = 8'h36;
  localparam logic [7:0] E_SET1 = 8'h37;
  localparam logic [7:0] E_STORE = 8'h41;
  localparam logic [7:0] E_VTABS = 8'h42;
  localparam logic [7:0] E_PAGE = 8'h43;
  localparam logic [7:0] E_HTABS = 8'h44;
  localparam logic [7:0] E_EMPH = 8'h45;
  localparam logic [7:0] E_EMPH_OFF = 8'h46;
  localparam logic [7:0] E_DSTR = 8'h47;
  localparam logic [7:0] E_DSTR_OFF = 8'h48;
  localparam logic [7:0] ARG_OFF = 8'h00;
  localparam logic [7:0] ARG_ON = 8'h01;
  // ----------------------------------------
  // Spacing (1/216 inch), page, tabs
  // ----------------------------------------
  localparam logic [7:0] SP_6 = 8'd36;
  localparam logic [7:0] SP_8 = 8'd27;
  localparam logic [7:0] SP_7_72 = 8'd21;
  localparam logic [7:0] SP_72_MUL = 8'd3;
  localparam logic [7:0] SP_72_MAX = 8'd85;
  localparam logic [7:0] PAGE_DEF = 8'd66;
  localparam logic [7:0] PAGE_MAX = 8'd127;
  localparam logic [7:0] LINES_PER_IN = 8'd6;
  localparam logic [7:0] INCH_MAX = 8'd22;
  localparam int HT_N = 133;
  localparam int VT_N = 128;
  localparam int GR_TAB_PITCH = 8;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_FMT = 12'h008;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic online;
    logic sel_fix;
    logic graphics;
  } pccp_ctrl_t;
  localparam pccp_ctrl_t CTRL_RST = 3'h7;
  typedef struct packed {
    logic cset2;
    logic dstrike;
    logic emph;
    logic uline;
    logic comp;
    logic dwide;
  } pccp_modes_t;
  typedef enum logic [2:0] {
    K_CHAR = 3'h0, K_TAB = 3'h1, K_FEED = 3'h2,
    K_FORM = 3'h3, K_LINE = 3'h4, K_FLUSH = 3'h5
  } pccp_kind_t;
  typedef struct packed {
    logic valid;
    pccp_kind_t kind;
    logic [7:0] arg;
  } pccp_act_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_LOW = 4'b0010, H_WAIT = 4'b0100, H_ACK = 4'b1000
  } pccp_hs_t;
  typedef enum logic [4:0] {
    P_TEXT = 5'b00001, P_ESC = 5'b00010, P_ARG = 5'b00100,
    P_LIST = 5'b01000, P_SKIP = 5'b10000
  } pccp_ps_t;
endpackage

// file: rtl/pccp_top.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Host waits for acknowledge or busy low
// [R2] Data latched while strobe held low
// [R3] About 5 us low acknowledge per byte
// [R4] Busy during entry, printing, offline, error
// [R5] Long init low resets parser, flushes buffer
// [R6] NUL ends tab lists, serves as option
// [R7] BEL sounds buzzer one second
// [R8] HT to next stop; graphics presets eight
// [R9] LF feeds one line, default sixth inch
// [R10] VT to next stop; graphics as LF
// [R11] FF to next page top, 66 lines
// [R12] CR ends line, prints, no feed
// [R13] SO sets double width; CR/LF/DC4 clear
// [R14] SI sets compressed, DC2 clears it
// [R15] DC1 selects unless fixed or graphics
// [R16] DC3 deselects with select request low
// [R17] CAN flushes, keeps modes but double width
// [R18] ESC makes next byte a selector
// [R19] ESC minus sets/clears underline, graphics only
// [R20] ESC 0 eighth inch, ESC 1 7/72
// [R21] ESC 2 applies stored spacing or sixth
// [R22] ESC 3 n gives n/216, graphics only
// [R23] ESC 6 selects set 2, graphics
// [R24] Only permitted mode combinations stay active
// [R25] Matrix: no underline, line-wide double width
// [R26] Unsupported selectors and parameters are discarded
module pccp_top
  import pccp_pkg::*;
#(
  parameter logic [15:0] INIT_CYCLES = 16'(pccp_pkg::INIT_CYC),
  parameter logic [26:0] BUZZ_CYCLES = 27'(pccp_pkg::BUZZ_CYC)
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Parallel link
  input wire logic strobe_n,
  input wire logic [7:0] data,
  input wire logic init_n,
  input wire logic select_request_line_n,
  output logic byte_taken_pulse_n,
  output logic busy,
  output logic selected,
  // Print engine
  input wire logic engine_busy,
  input wire logic engine_error,
  output pccp_pkg::pccp_act_t act,
  output pccp_pkg::pccp_modes_t modes,
  output logic [7:0] spacing,
  output logic buzzer
);
  import pccp_pkg::*;

  typedef struct packed {
    pccp_hs_t hs;
    pccp_ps_t ps;
    logic [7:0] sel;
    logic inch;
    logic [15:0] cnt;
    logic [15:0] icnt;
    logic [26:0] buzz;
    logic [7:0] rx;
    pccp_ctrl_t ctrl;
    pccp_modes_t md;
    logic line_dw;
    logic [7:0] spacing;
    logic [7:0] var_sp;
    logic var_set;
    logic [7:0] page;
    logic [7:0] line;
    logic [7:0] col;
    logic [7:0] last;
    logic [HT_N-1:0] htab;
    logic [VT_N-1:0] vtab;
    logic [HT_N-1:0] tnew;
    logic sel_q;
    pccp_act_t act;
    pccp_modes_t out_md;
    logic ack_n;
    logic busy;
    logic buzzer;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pccp_st_t;

  pccp_st_t s_q;
  pccp_st_t s_d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] next_stop(input logic [HT_N-1:0] m, input logic [7:0] cur);
    logic [7:0] r;
    r = 8'h00;
    for (int i = HT_N - 1; i > 0; i--) begin
      if (m[i] && (8'(i) > cur)) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  function automatic pccp_st_t fresh(input pccp_ctrl_t c);
    pccp_st_t r;
    r = '0;
    r.hs = H_IDLE;
    r.ps = P_TEXT;
    r.ctrl = c;
    r.ack_n = 1'b1;
    r.busy = 1'b1;
    r.spacing = SP_6;
    r.page = PAGE_DEF;
    r.sel_q = 1'b1;
    // [R8] graphics tab preset
    for (int i = 1; i < HT_N; i++) begin
      r.htab[i] = c.graphics && ((i % GR_TAB_PITCH) == 0);
    end
    return r;
  endfunction

  function automatic logic [7:0] line_inc(input logic [7:0] l, input logic [7:0] pg);
    return (l + 8'h01 >= pg) ? 8'h00 : l + 8'h01;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [7:0] b;
  logic [7:0] t;
  logic parse;
  logic gfx;
  logic sw_ok;

  always_comb begin
    b = s_q.rx;
    t = 8'h00;
    gfx = s_q.ctrl.graphics;
    sw_ok = !s_q.ctrl.graphics && !s_q.ctrl.sel_fix;
    s_d = s_q;
    s_d.act = '0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    parse = 1'b0;
    if (s_q.buzz != 27'h0) begin
      s_d.buzz = s_q.buzz - 27'h1;
    end
    if (!init_n) begin
      if (s_q.icnt != INIT_CYCLES) begin
        s_d.icnt = s_q.icnt + 16'h1;
      end
    end else begin
      s_d.icnt = 16'h0;
    end

    unique case (s_q.hs)
      H_IDLE: begin
        // [R2] latch once strobe is steadily low
        if (!strobe_n) begin
          s_d.cnt = s_q.cnt + 16'h1;
          if (s_q.cnt == STB_LAST) begin
            s_d.rx = data;
            s_d.cnt = 16'h0;
            s_d.hs = H_LOW;
          end
        end else begin
          s_d.cnt = 16'h0;
        end
      end
      H_LOW: begin
        if (strobe_n) begin
          parse = 1'b1;
          s_d.hs = H_WAIT;
        end
      end
      H_WAIT: begin
        // [R3] acknowledge once engine can take more
        if (!engine_busy) begin
          s_d.ack_n = 1'b0;
          s_d.cnt = 16'h0;
          s_d.hs = H_ACK;
        end
      end
      H_ACK: begin
        s_d.cnt = s_q.cnt + 16'h1;
        if (s_q.cnt == ACK_LAST) begin
          s_d.ack_n = 1'b1;
          s_d.cnt = 16'h0;
          s_d.hs = H_IDLE;
        end
      end
    endcase

    if (parse && !s_q.sel_q) begin
      // [R15] only select code passes while deselected
      if (b == C_DC1 && sw_ok) begin
        s_d.sel_q = 1'b1;
      end
    end else if (parse) begin
      unique case (s_q.ps)
        P_TEXT: begin
          if (b == C_BEL) begin
            // [R7] buzzer one second
            s_d.buzz = BUZZ_CYCLES;
          end else if (b == C_HT) begin
            // [R8] next horizontal stop
            t = next_stop(s_q.htab, s_q.col);
            if (t != 8'h00) begin
              s_d.act = '{1'b1, K_TAB, t};
              s_d.col = t;
            end
          end else if (b == C_LF || (b == C_VT && (gfx || s_q.vtab == '0))) begin
            // [R9] one line at current spacing, [R10] VT fallback, [R13] clears width
            s_d.act = '{1'b1, K_FEED, 8'h01};
            s_d.line = line_inc(s_q.line, s_q.page);
            s_d.col = 8'h00;
            s_d.md.dwide = 1'b0;
            s_d.line_dw = 1'b0;
          end else if (b == C_VT) begin
            // [R10] next vertical stop, else next page
            t = next_stop({{(HT_N-VT_N){1'b0}}, s_q.vtab}, s_q.line);
            if (t != 8'h00 && t < s_q.page) begin
              s_d.act = '{1'b1, K_FEED, t - s_q.line};
              s_d.line = t;
            end else begin
              s_d.act = '{1'b1, K_FORM, s_q.page - s_q.line};
              s_d.line = 8'h00;
            end
            s_d.col = 8'h00;
          end else if (b == C_FF) begin
            // [R11] feed rest of page
            s_d.act = '{1'b1, K_FORM, s_q.page - s_q.line};
            s_d.line = 8'h00;
            s_d.col = 8'h00;
          end else if (b == C_CR) begin
            // [R12] print line, no feed; [R13] clears width
            s_d.act = '{1'b1, K_LINE, 8'h00};
            s_d.col = 8'h00;
            s_d.md.dwide = 1'b0;
            s_d.line_dw = 1'b0;
          end else if (b == C_SO) begin
            // [R13] double width on
            s_d.md.dwide = 1'b1;
            s_d.line_dw = 1'b1;
          end else if (b == C_SI) begin
            // [R14] compressed on; [R24] drops emphasis and double strike
            s_d.md.comp = 1'b1;
            s_d.md.emph = 1'b0;
            s_d.md.dstrike = 1'b0;
          end else if (b == C_DC2) begin
            // [R14] compressed off
            s_d.md.comp = 1'b0;
          end else if (b == C_DC3) begin
            // [R16] deselect needs request line low
            if (sw_ok && !select_request_line_n) begin
              s_d.sel_q = 1'b0;
            end
          end else if (b == C_DC4) begin
            // [R13] double width off
            s_d.md.dwide = 1'b0;
          end else if (b == C_CAN) begin
            // [R17] flush, only double width is lost
            s_d.act = '{1'b1, K_FLUSH, 8'h00};
            s_d.col = 8'h00;
            s_d.md.dwide = 1'b0;
            s_d.line_dw = 1'b0;
          end else if (b == C_ESC) begin
            // [R18] next byte is a selector
            s_d.ps = P_ESC;
          end else if (b >= C_SPACE && b != C_DEL) begin
            s_d.act = '{1'b1, K_CHAR, b};
            if (s_q.col != 8'hff) begin
              s_d.col = s_q.col + 8'h01;
            end
          end
        end
        P_ESC: begin
          s_d.ps = P_TEXT;
          s_d.sel = b;
          s_d.inch = 1'b0;
          s_d.last = 8'h00;
          s_d.tnew = '0;
          unique case (b)
            // [R19] [R22] [R26] graphics-only argument, else skipped
            E_ULINE, E_SPN: s_d.ps = gfx ? P_ARG : P_SKIP;
            E_STORE, E_PAGE: s_d.ps = P_ARG;
            E_VTABS, E_HTABS: s_d.ps = P_LIST;
            // [R20] fixed spacings
            E_SP8: s_d.spacing = SP_8;
            E_SP7: s_d.spacing = SP_7_72;
            // [R21] stored spacing or sixth inch
            E_SPVAR: s_d.spacing = s_q.var_set ? s_q.var_sp : SP_6;
            // [R23] character set selection
            E_SET2: s_d.md.cset2 = gfx | s_q.md.cset2;
            E_SET1: s_d.md.cset2 = gfx ? 1'b0 : s_q.md.cset2;
            // [R24] emphasis and double strike exclude compressed
            E_EMPH: begin
              s_d.md.emph = 1'b1;
              s_d.md.comp = 1'b0;
            end
            E_EMPH_OFF: s_d.md.emph = 1'b0;
            E_DSTR: begin
              s_d.md.dstrike = 1'b1;
              s_d.md.comp = 1'b0;
            end
            E_DSTR_OFF: s_d.md.dstrike = 1'b0;
            default: s_d.ps = P_TEXT;
          endcase
        end
        P_ARG: begin
          s_d.ps = P_TEXT;
          if (s_q.sel == E_ULINE) begin
            // [R19] [R6] NUL turns underline off
            if (b == ARG_ON) begin
              s_d.md.uline = 1'b1;
            end else if (b == ARG_OFF) begin
              s_d.md.uline = 1'b0;
            end
          end else if (s_q.sel == E_SPN) begin
            // [R22] n/216 with n from 1
            if (b != 8'h00) begin
              s_d.spacing = b;
            end
          end else if (s_q.sel == E_STORE) begin
            // [R21] stored for a later ESC 2
            if (b != 8'h00 && b <= SP_72_MAX) begin
              s_d.var_sp = b * SP_72_MUL;
              s_d.var_set = 1'b1;
            end
          end else if (s_q.inch) begin
            if (b != 8'h00 && b <= INCH_MAX) begin
              s_d.page = b * LINES_PER_IN;
            end
          end else if (b == C_NUL && gfx) begin
            // [R6] NUL option selects inch form
            s_d.inch = 1'b1;
            s_d.ps = P_ARG;
          end else if (b != 8'h00 && b <= PAGE_MAX) begin
            s_d.page = b;
          end
        end
        P_LIST: begin
          if (b == C_NUL) begin
            // [R6] NUL commits the list; [R26] graphics drops vertical list
            s_d.ps = P_TEXT;
            if (s_q.sel == E_HTABS) begin
              s_d.htab = s_q.tnew;
            end else if (!gfx) begin
              s_d.vtab = s_q.tnew[VT_N-1:0];
            end
          end else if (b > s_q.last && 32'(b) < ((s_q.sel == E_HTABS) ? HT_N : VT_N)) begin
            s_d.tnew[b] = 1'b1;
            s_d.last = b;
          end
        end
        P_SKIP: begin
          // [R26] swallow one argument
          s_d.ps = P_TEXT;
        end
        default: s_d.ps = P_TEXT;
      endcase
    end

    // [R25] matrix holds double width for whole line, no underline
    s_d.out_md = s_d.md;
    if (!gfx) begin
      s_d.out_md.dwide = s_d.md.dwide | s_d.line_dw;
      s_d.out_md.uline = 1'b0;
    end
    s_d.buzzer = s_d.buzz != 27'h0;

    // [R5] long init pulse restarts controller and flushes
    if (!init_n && s_q.icnt == INIT_CYCLES - 16'h1) begin
      s_d = fresh(s_q.ctrl);
      s_d.icnt = INIT_CYCLES;
      s_d.act = '{1'b1, K_FLUSH, 8'h00};
    end

    // APB: answer one cycle into the access phase
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      unique case (paddr)
        A_CTRL: s_d.prdata = {29'h0, s_q.ctrl};
        A_STAT: s_d.prdata = {15'h0, s_q.ps, s_q.hs, s_q.sel_q, s_q.out_md, 1'b0};
        A_FMT: s_d.prdata = {s_q.page, s_q.line, s_q.col, s_q.spacing};
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_q.pready && pwrite && paddr == A_CTRL) begin
      s_d.ctrl = pwdata[2:0];
    end

    // [R4] busy on entry, engine, offline, error
    s_d.busy = (s_d.hs != H_IDLE) || !strobe_n || engine_busy || engine_error ||
               !s_d.ctrl.online || !init_n;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= fresh(CTRL_RST);
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign byte_taken_pulse_n = s_q.ack_n;
  assign busy = s_q.busy;
  assign selected = s_q.sel_q;
  assign act = s_q.act;
  assign modes = s_q.out_md;
  assign spacing = s_q.spacing;
  assign buzzer = s_q.buzzer;
endmodule

// file: verification/pccp_monitor.sv
`timescale 1ns/100ps
module pccp_monitor
  import pccp_pkg::*;
#(
  parameter logic [26:0] BUZZ_CYCLES = 27'd50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic strobe_n,
  input wire logic init_n,
  input wire logic byte_taken_pulse_n,
  input wire logic busy,
  // Engine side
  input wire logic engine_busy,
  input wire logic engine_error,
  input wire pccp_pkg::pccp_act_t act,
  input wire pccp_pkg::pccp_modes_t modes,
  input wire logic [7:0] spacing,
  input wire logic buzzer
);
  logic [15:0] ack_cnt_q;
  logic [26:0] buz_cnt_q;
  // Run lengths of the low acknowledge and of the buzzer
  always_ff @(posedge clk) begin
    if (rst || byte_taken_pulse_n) begin
      ack_cnt_q <= 16'h0;
    end else begin
      ack_cnt_q <= ack_cnt_q + 16'h1;
    end
    if (rst || !buzzer) begin
      buz_cnt_q <= 27'h0;
    end else begin
      buz_cnt_q <= buz_cnt_q + 27'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_init_held;
    !init_n ##1 !init_n;
  endsequence
  sequence s_engine_held;
    (engine_busy || engine_error) ##1 (engine_busy || engine_error);
  endsequence
  sequence s_act_done;
    act.valid && init_n && !engine_busy;
  endsequence
  property p_ack_len;
    $rose(byte_taken_pulse_n) |-> ack_cnt_q == 16'(ACK_CYC);
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack low length wrong");
  property p_ack_max;
    ack_cnt_q <= 16'(ACK_CYC);
  endproperty
  a_ack_max: assert property (p_ack_max) else $error("ack low too long");
  property p_act_ack;
    s_act_done |=> $fell(byte_taken_pulse_n);
  endproperty
  a_act_ack: assert property (p_act_ack) else $error("no ack after byte");
  property p_busy_ack;
    !byte_taken_pulse_n |-> busy;
  endproperty
  a_busy_ack: assert property (p_busy_ack) else $error("busy low during ack");
  property p_busy_strobe;
    $fell(strobe_n) |-> ##[1:2] busy;
  endproperty
  a_busy_strobe: assert property (p_busy_strobe) else $error("busy late on entry");
  property p_busy_engine;
    s_engine_held |-> busy;
  endproperty
  a_busy_engine: assert property (p_busy_engine) else $error("busy low while printing");
  property p_busy_init;
    s_init_held |-> busy;
  endproperty
  a_busy_init: assert property (p_busy_init) else $error("busy low during init");
  property p_buzz_len;
    $fell(buzzer) |-> buz_cnt_q >= BUZZ_CYCLES && buz_cnt_q <= BUZZ_CYCLES + 27'd1;
  endproperty
  a_buzz_len: assert property (p_buzz_len) else $error("buzzer length wrong");
  property p_modes_excl;
    !(modes.comp && (modes.emph || modes.dstrike));
  endproperty
  a_modes_excl: assert property (p_modes_excl) else $error("illegal mode mix");
  property p_reset_vals;
    $past(rst) |-> spacing == SP_6 && modes == 6'h00 && !buzzer;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
endmodule
bind pccp_top pccp_monitor #(.BUZZ_CYCLES(BUZZ_CYCLES)) i_pccp_monitor (
  .clk(clk), .rst(rst), .strobe_n(strobe_n), .init_n(init_n), .byte_taken_pulse_n(byte_taken_pulse_n),
  .busy(busy), .engine_busy(engine_busy), .engine_error(engine_error), .act(act), .modes(modes),
  .spacing(spacing), .buzzer(buzzer));

// file: verification/pccp_host.sv
`timescale 1ns/100ps
module pccp_host (
  // Clock
  input wire logic clk,
  // Parallel link
  input wire logic busy,
  output logic strobe_n,
  output logic [7:0] data,
  output logic init_n,
  output logic select_request_line_n
);
  int gap = 0;
  initial begin
    strobe_n = 1'b1;
    data = 8'h5a;
    init_n = 1'b1;
    select_request_line_n = 1'b0;
  end
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic send(input logic [7:0] b);
    repeat (gap) @(posedge clk);
    wait_idle();
    data <= b;
    @(posedge clk);
    // strobe low past the minimum width
    strobe_n <= 1'b0;
    repeat (60) @(posedge clk);
    strobe_n <= 1'b1;
    @(posedge clk);
    // Released lines must not keep the byte
    data <= ~b;
    repeat (3) @(posedge clk);
    wait_idle();
  endtask
  task automatic init_pulse(input int cyc);
    init_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    init_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import pccp_pkg::*;
  typedef struct packed {logic [2:0] k; logic [7:0] a; logic c;} pccp_exp_t;
  localparam logic [2:0] NA = 3'h7;
  localparam logic [7:0] X = 8'hff;
  logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, busy, selected, ce = 1'b1;
  logic engine_busy = 1'b0, engine_error = 1'b0, strobe_n, init_n, slin_n, ack_n, buzzer, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] data, spacing, pb, pm;
  logic [2:0] pk;
  pccp_act_t act;
  pccp_modes_t modes;
  pccp_exp_t exp_q[$], pe;
  int checks = 0, n_mismatch = 0, nbuz = 0, run = 0, seed = 25, i;
  logic [7:0] sel_t [6] = '{E_SPVAR, E_SP8, E_SP7, E_STORE, E_SPVAR, E_SPN};
  logic [7:0] arg_t [6] = '{8'd0, 8'd0, 8'd0, 8'd10, 8'd0, 8'd54};
  logic [7:0] pit_t [6] = '{8'd36, 8'd27, 8'd21, 8'd21, 8'd30, 8'd54};
  logic [18:0] mt [35] = '{{C_SO, 8'h01, NA}, {C_CR, 8'h00, K_LINE}, {C_SO, 8'h01, NA},
    {C_LF, 8'h00, K_FEED}, {C_SO, 8'h01, NA}, {C_DC4, 8'h00, NA}, {C_SI, 8'h02, NA},
    {C_ESC, X, NA}, {E_EMPH, 8'h08, NA}, {C_SI, 8'h02, NA}, {C_DC2, 8'h00, NA}, {C_SI, 8'h02, NA},
    {C_SO, 8'h03, NA}, {C_CAN, 8'h02, K_FLUSH}, {C_DC2, 8'h00, NA}, {C_ESC, X, NA}, {E_ULINE, X, NA},
    {ARG_ON, 8'h04, NA}, {C_ESC, X, NA}, {E_ULINE, X, NA}, {ARG_OFF, 8'h00, NA}, {C_ESC, X, NA},
    {E_SET2, 8'h20, NA}, {C_ESC, X, NA}, {E_SET1, 8'h00, NA}, {C_ESC, X, NA}, {E_HTABS, X, NA},
    {8'd10, X, NA}, {C_NUL, X, NA}, {8'h42, X, K_CHAR}, {C_ESC, X, NA}, {E_VTABS, X, NA},
    {8'd5, X, NA}, {C_NUL, X, NA}, {C_BEL, 8'h00, NA}};
  pccp_top #(.INIT_CYCLES(16'd20), .BUZZ_CYCLES(27'd50)) i_pccp_top (
    .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strobe_n(strobe_n),
    .data(data), .init_n(init_n), .select_request_line_n(slin_n), .byte_taken_pulse_n(ack_n),
    .busy(busy), .selected(selected), .engine_busy(engine_busy), .engine_error(engine_error),
    .act(act), .modes(modes), .spacing(spacing), .buzzer(buzzer));
  pccp_host i_pccp_host (.clk(clk), .busy(busy), .strobe_n(strobe_n), .data(data), .init_n(init_n),
    .select_request_line_n(slin_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Idle cycle after release keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tx(input logic [7:0] b, input logic [2:0] k = NA, input logic [7:0] a = 8'h0,
                    input logic c = 1'b0);
    if (k != NA) exp_q.push_back('{k, a, c});
    i_pccp_host.send(b);
  endtask
  // ----
  // Result watcher
  // ----
  always @(posedge clk) begin
    if (!rst && act.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'(act.kind), 32'hff);
      end else begin
        pe = exp_q.pop_front();
        chk(32'(act.kind), 32'(pe.k));
        if (pe.c) chk(32'(act.arg), 32'(pe.a));
      end
    end
    if (buzzer === 1'b1) begin
      run++;
    end else if (run != 0) begin
      nbuz++;
      chk(32'(run >= 50 && run <= 51), 32'h1);
      run = 0;
    end
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'(spacing), 32'd36);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, A_STAT, 32'hff);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    for (i = 0; i < 6; i++) begin
      tx(C_ESC);
      tx(sel_t[i]);
      if (arg_t[i] != 8'd0) tx(arg_t[i]);
      chk(32'(spacing), 32'(pit_t[i]));
    end
    tx(C_CR, K_LINE);
    tx(8'h41, K_CHAR, 8'h41, 1'b1);
    tx(C_HT, K_TAB);
    tx(C_LF, K_FEED, 8'd1, 1'b1);
    tx(C_VT, K_FEED, 8'd1, 1'b1);
    tx(C_FF, K_FORM);
    for (i = 0; i < 35; i++) begin
      {pb, pm, pk} = mt[i];
      tx(pb, pk, pb, pk == K_CHAR);
      if (pm != X) chk(32'(modes), 32'(pm));
    end
    chk(32'(nbuz), 32'h1);
    tx(C_DC3);
    chk(32'(selected), 32'h1);
    for (i = 0; i < 6; i++) begin
      i_pccp_host.gap = $random(seed) & 7;
      pb = 8'h21 + 8'($unsigned($random(seed)) % 94);
      tx(pb, K_CHAR, pb, 1'b1);
    end
    i_pccp_host.gap = 0;
    engine_busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(busy), 32'h1);
    engine_busy <= 1'b0;
    engine_error <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(busy), 32'h1);
    engine_error <= 1'b0;
    // Frozen state keeps busy high although its causes are gone
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(busy), 32'h1);
    ce <= 1'b1;
    apb(1'b1, A_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk(32'(busy), 32'h1);
    apb(1'b1, A_CTRL, 32'h4);
    tx(C_ESC);
    tx(E_ULINE);
    tx(ARG_ON);
    tx(8'h42, K_CHAR, 8'h42, 1'b1);
    chk(32'(modes), 32'h0);
    tx(C_ESC);
    tx(E_VTABS);
    tx(8'd5);
    tx(C_NUL);
    tx(C_VT, K_FEED, 8'd4, 1'b1);
    tx(C_DC3);
    chk(32'(selected), 32'h0);
    tx(8'h43);
    tx(C_DC1);
    chk(32'(selected), 32'h1);
    tx(C_SO);
    exp_q.push_back('{K_FLUSH, 8'h0, 1'b0});
    i_pccp_host.init_pulse(25);
    repeat (2) @(posedge clk);
    chk(32'(modes), 32'h0);
    chk(32'(spacing), 32'd36);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h4);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h7);
    chk(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
